/* File: core/sleep_ctrl.sv */
// Sleep mode controller gating clocks and oscillators
`timescale 1ns/10ps
module sleep_ctrl
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        mode_we_i,
  input  wire logic [2:0]  mode_i,
  input  wire logic        sleep_en_i,
  input  wire logic        sleep_req_i,
  input  wire logic        ext_irq_i,
  input  wire logic        int_irq_i,
  output logic      [2:0]  mode_o,
  output logic             asleep_o,
  output logic             mode_err_o,
  output logic             cpu_clk_en_o,
  output logic             io_clk_en_o,
  output logic             adc_clk_en_o,
  output logic             async_clk_en_o,
  output logic             osc_en_o,
  output logic             irq_clk_en_o,
  output logic             mem_clk_en_o
);

  // ----------------------------------------
  // Package consistency checks
  // ----------------------------------------
  if (sleep_ctrl_pkg::MODE_W != 3)
  begin : g_mode_w_check
    $error("Mode field width must be three bits");
  end

  if (sleep_ctrl_pkg::EN_W != 7)
  begin : g_en_w_check
    $error("Enable vector width must be seven bits");
  end

  // ----------------------------------------
  // State, mode field and enable vector
  // ----------------------------------------
  sleep_ctrl_pkg::state_t state;
  sleep_ctrl_pkg::state_t next_state;
  logic [2:0]             mode;
  logic [2:0]             next_mode;
  logic                   mode_err;
  logic                   next_mode_err;
  logic [6:0]             en;
  logic [6:0]             next_en;

  // ----------------------------------------
  // Mode decoding
  // ----------------------------------------
  function automatic logic mode_valid(input logic [2:0] m);
    mode_valid = (m == sleep_ctrl_pkg::MODE_IDLE)
              || (m == sleep_ctrl_pkg::MODE_NOISE_RED)
              || (m == sleep_ctrl_pkg::MODE_PWR_DOWN)
              || (m == sleep_ctrl_pkg::MODE_PWR_SAVE)
              || (m == sleep_ctrl_pkg::MODE_STANDBY)
              || (m == sleep_ctrl_pkg::MODE_EXT_STBY);
  endfunction

  function automatic logic [6:0] sleep_en_vec(input logic [2:0] m);
    logic [6:0] v;
    v = 7'h00;
    case (m)
      sleep_ctrl_pkg::MODE_IDLE:
      begin
        v = sleep_ctrl_pkg::EN_ALL;                                  // RL2
        v[sleep_ctrl_pkg::EN_CPU] = 1'b0;
      end
      sleep_ctrl_pkg::MODE_NOISE_RED:
      begin
        v[sleep_ctrl_pkg::EN_ADC]   = 1'b1;                          // RL5
        v[sleep_ctrl_pkg::EN_ASYNC] = 1'b1;
        v[sleep_ctrl_pkg::EN_OSC]   = 1'b1;
        v[sleep_ctrl_pkg::EN_IRQ]   = 1'b1;
      end
      sleep_ctrl_pkg::MODE_PWR_DOWN:
      begin
        v = 7'h00;                                                   // RL3
      end
      sleep_ctrl_pkg::MODE_PWR_SAVE:
      begin
        v[sleep_ctrl_pkg::EN_ASYNC] = 1'b1;                          // RL4
      end
      sleep_ctrl_pkg::MODE_STANDBY:
      begin
        v[sleep_ctrl_pkg::EN_OSC] = 1'b1;                            // RL6
      end
      sleep_ctrl_pkg::MODE_EXT_STBY:
      begin
        v[sleep_ctrl_pkg::EN_OSC]   = 1'b1;                          // RL7
        v[sleep_ctrl_pkg::EN_ASYNC] = 1'b1;
      end
      default:
      begin
        v = 7'h00;
      end
    endcase
    sleep_en_vec = v;
  endfunction

  // ----------------------------------------
  // Decoded mode and state
  // ----------------------------------------
  wire logic is_idle      = (mode == sleep_ctrl_pkg::MODE_IDLE);
  wire logic is_noise_red = (mode == sleep_ctrl_pkg::MODE_NOISE_RED);
  wire logic full_clock   = is_idle || is_noise_red;
  wire logic mode_ok      = mode_valid(mode);
  wire logic running      = (state == sleep_ctrl_pkg::ST_RUN);
  wire logic sleeping     = (state == sleep_ctrl_pkg::ST_SLEEP);

  // ----------------------------------------
  // Sleep entry and wake
  // ----------------------------------------
  wire logic wake         = ext_irq_i || (full_clock && int_irq_i);      // RL3
  wire logic enter        = sleep_en_i && sleep_req_i && mode_ok;        // RL8
  wire logic mode_write   = mode_we_i && running;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      sleep_ctrl_pkg::ST_RUN:
      begin
        if (enter && !wake)
          next_state = sleep_ctrl_pkg::ST_SLEEP;
      end
      sleep_ctrl_pkg::ST_SLEEP:
      begin
        if (wake)
          next_state = sleep_ctrl_pkg::ST_RUN;                       // RL8
      end
      default:
      begin
        next_state = sleep_ctrl_pkg::ST_RUN;
      end
    endcase
  end

  assign next_en       = (next_state == sleep_ctrl_pkg::ST_SLEEP) ? sleep_en_vec(mode)
                                                                  : sleep_ctrl_pkg::EN_ALL;
  assign next_mode     = mode_write ? mode_i : mode;                    // RL1
  assign next_mode_err = mode_write ? !mode_valid(mode_i) : mode_err;

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state <= sleep_ctrl_pkg::ST_RUN;
    end
    else if (ce_i)
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Mode field
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      mode <= sleep_ctrl_pkg::MODE_RESET;
    end
    else if (ce_i)
    begin
      mode <= next_mode;                                             // RL1
    end
  end

  // ----------------------------------------
  // Invalid mode flag
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      mode_err <= 1'b0;
    end
    else if (ce_i)
    begin
      mode_err <= next_mode_err;
    end
  end

  // ----------------------------------------
  // Enable vector
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      en <= sleep_ctrl_pkg::EN_ALL;
    end
    else if (ce_i)
    begin
      en <= next_en;                                                 // RL8
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign mode_o         = mode;
  assign asleep_o       = sleeping;
  assign mode_err_o     = mode_err;
  assign cpu_clk_en_o   = en[sleep_ctrl_pkg::EN_CPU];
  assign io_clk_en_o    = en[sleep_ctrl_pkg::EN_IO];
  assign adc_clk_en_o   = en[sleep_ctrl_pkg::EN_ADC];
  assign async_clk_en_o = en[sleep_ctrl_pkg::EN_ASYNC];
  assign osc_en_o       = en[sleep_ctrl_pkg::EN_OSC];
  assign irq_clk_en_o   = en[sleep_ctrl_pkg::EN_IRQ];
  assign mem_clk_en_o   = en[sleep_ctrl_pkg::EN_MEM];

endmodule

/* File: core/sleep_ctrl_pkg.sv */
// Constants for the sleep mode clock gating controller
// Contract
// RL1: Six sleep modes exist; software picks any one before sleeping.
// RL2: Idle halts CPU clock; serial, converter, memory, timers, interrupts keep clocking.
// RL3: Power-down stops oscillator, keeps registers; only external interrupt or reset wakes.
// RL4: Power-save keeps asynchronous timer counting; rest sleeps as power-down.
// RL5: Noise-reduction halts CPU and I/O except asynchronous timer and converter.
// RL6: Standby keeps main oscillator running while everything else sleeps.
// RL7: Extended standby keeps main oscillator and asynchronous timer running.
// RL8: Mode field written by software; sleep starts on CPU request; wake restores clocks.
package sleep_ctrl_pkg;

  // ----------------------------------------
  // Mode encodings
  // ----------------------------------------
  localparam int          MODE_W          = 3;
  localparam logic [2:0]  MODE_IDLE       = 3'h0;
  localparam logic [2:0]  MODE_NOISE_RED  = 3'h1;
  localparam logic [2:0]  MODE_PWR_DOWN   = 3'h2;
  localparam logic [2:0]  MODE_PWR_SAVE   = 3'h3;
  localparam logic [2:0]  MODE_STANDBY    = 3'h6;
  localparam logic [2:0]  MODE_EXT_STBY   = 3'h7;
  localparam logic [2:0]  MODE_RESET      = 3'h0;

  // ----------------------------------------
  // Enable vector bit positions
  // ----------------------------------------
  localparam int          EN_W            = 7;
  localparam int          EN_CPU          = 0;
  localparam int          EN_IO           = 1;
  localparam int          EN_ADC          = 2;
  localparam int          EN_ASYNC        = 3;
  localparam int          EN_OSC          = 4;
  localparam int          EN_IRQ          = 5;
  localparam int          EN_MEM          = 6;
  localparam logic [6:0]  EN_ALL          = 7'h7F;

  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } state_t;

endpackage

/* File: sim/sleep_ctrl_assertions.sv */
// Checker for the sleep mode controller ports
`timescale 1ns/10ps
module sleep_ctrl_assertions
(
  input wire logic       clk_i, rstn_i, ce_i, mode_we_i, sleep_en_i, sleep_req_i, ext_irq_i,
  input wire logic       int_irq_i, asleep_o, mode_err_o, cpu_clk_en_o, io_clk_en_o,
  input wire logic       adc_clk_en_o, async_clk_en_o, osc_en_o, irq_clk_en_o, mem_clk_en_o,
  input wire logic [2:0] mode_i, mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire logic ok = mode_o != 3'h4 && mode_o != 3'h5 && !mode_err_o;
  property p_mode;
    ce_i && mode_we_i && !asleep_o && mode_i != 3'h4 && mode_i != 3'h5 |=> mode_o == $past(mode_i);
  endproperty
  a_mode: assert property (p_mode) else $error("mode field not written");
  property p_idle;
    asleep_o && mode_o == 3'h0 |-> !cpu_clk_en_o && io_clk_en_o && adc_clk_en_o && mem_clk_en_o;
  endproperty
  a_idle: assert property (p_idle) else $error("idle enables");
  property p_pd;
    asleep_o && mode_o == 3'h2 |-> !osc_en_o && !async_clk_en_o && !irq_clk_en_o;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down enables");
  property p_ps;
    asleep_o && mode_o == 3'h3 |-> async_clk_en_o && !osc_en_o && !adc_clk_en_o;
  endproperty
  a_ps: assert property (p_ps) else $error("power-save enables");
  property p_nr;
    asleep_o && mode_o == 3'h1 |-> adc_clk_en_o && async_clk_en_o && !io_clk_en_o;
  endproperty
  a_nr: assert property (p_nr) else $error("noise mode enables");
  property p_sb;
    asleep_o && mode_o == 3'h6 |-> osc_en_o && !async_clk_en_o && !cpu_clk_en_o;
  endproperty
  a_sb: assert property (p_sb) else $error("standby enables");
  property p_es;
    asleep_o && mode_o == 3'h7 |-> osc_en_o && async_clk_en_o && !io_clk_en_o;
  endproperty
  a_es: assert property (p_es) else $error("extended standby enables");
  property p_go;
    ce_i && !asleep_o && sleep_en_i && sleep_req_i && !ext_irq_i && !int_irq_i && ok
      && !mode_we_i |=> asleep_o && !cpu_clk_en_o;
  endproperty
  a_go: assert property (p_go) else $error("sleep request not taken");
  property p_wake;
    asleep_o && ce_i && ext_irq_i |=> !asleep_o && cpu_clk_en_o && osc_en_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
endmodule

/* File: sim/tb_sleep_ctrl.sv */
// Self-checking bench for the sleep mode controller
`timescale 1ns/10ps
module tb_sleep_ctrl;
  logic       clk_i = 0, rstn_i = 0, ce_i = 1, mode_we_i = 0, sleep_en_i = 0, sleep_req_i = 0;
  logic       ext_irq_i = 0, int_irq_i = 0, asleep_o, mode_err_o, cpu_clk_en_o, io_clk_en_o;
  logic       adc_clk_en_o, async_clk_en_o, osc_en_o, irq_clk_en_o, mem_clk_en_o;
  logic [2:0] mode_i = 3'h0, mode_o;
  int         errors = 0, tests_run = 0, cyc = 0;
  wire logic [6:0] en = {mem_clk_en_o, irq_clk_en_o, osc_en_o, async_clk_en_o,
                         adc_clk_en_o, io_clk_en_o, cpu_clk_en_o};
  sleep_ctrl uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .mode_we_i(mode_we_i), .mode_i(mode_i),
    .sleep_en_i(sleep_en_i), .sleep_req_i(sleep_req_i), .ext_irq_i(ext_irq_i),
    .int_irq_i(int_irq_i), .mode_o(mode_o), .asleep_o(asleep_o), .mode_err_o(mode_err_o),
    .cpu_clk_en_o(cpu_clk_en_o), .io_clk_en_o(io_clk_en_o), .adc_clk_en_o(adc_clk_en_o),
    .async_clk_en_o(async_clk_en_o), .osc_en_o(osc_en_o), .irq_clk_en_o(irq_clk_en_o),
    .mem_clk_en_o(mem_clk_en_o)
  );
  initial forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin cyc <= cyc + 1; if (cyc == 3000) begin errors++; close_out(); end end
  function automatic logic [6:0] exp_en(input logic [2:0] m);
    case (m)
      3'h0: return 7'h7E; 3'h1: return 7'h3C; 3'h3: return 7'h08;
      3'h6: return 7'h10; 3'h7: return 7'h18; default: return 7'h00;
    endcase
  endfunction
  task automatic chk(input string n, input logic [6:0] e, input logic [6:0] g);
    tests_run++;
    if (g !== e) begin errors++; $display("wrong value %s expected %h seen %h", n, e, g); end
  endtask
  task automatic close_out();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic go(input logic [2:0] m, input logic w);
    logic v, k;
    v = m != 3'h4 && m != 3'h5;
    k = v && w && m > 3'h1;
    @(posedge clk_i) begin mode_we_i <= 1; mode_i <= m; end
    @(posedge clk_i) begin mode_we_i <= 0; sleep_en_i <= 1; sleep_req_i <= 1; end
    @(posedge clk_i) sleep_req_i <= 0;
    #1 chk("err", {6'h0, !v}, {6'h0, mode_err_o});
    chk("asleep", {6'h0, v}, {6'h0, asleep_o});
    chk("en", v ? exp_en(m) : 7'h7F, en);
    @(posedge clk_i) begin int_irq_i <= w; ext_irq_i <= !w; mode_we_i <= 1; mode_i <= m ^ 3'h1; end
    @(posedge clk_i) begin int_irq_i <= 0; ext_irq_i <= 0; mode_we_i <= 0; end
    #1 chk("woke", {6'h0, k}, {6'h0, asleep_o});
    chk("en2", k ? exp_en(m) : 7'h7F, en);
    if (v) chk("mode", {4'h0, m}, {4'h0, mode_o});
    @(posedge clk_i) begin ext_irq_i <= 1; sleep_en_i <= 0; end
    @(posedge clk_i) ext_irq_i <= 0;
    $display("test mode %0h wake %0b done", m, w);
  endtask
  task automatic corner();
    @(posedge clk_i) begin mode_we_i <= 1; mode_i <= 3'h2; end
    @(posedge clk_i) begin mode_we_i <= 0; sleep_req_i <= 1; end
    @(posedge clk_i) begin sleep_en_i <= 1; ext_irq_i <= 1; end
    #1 chk("no enable", 7'h00, {6'h0, asleep_o});
    @(posedge clk_i) begin ext_irq_i <= 0; ce_i <= 0; end
    @(posedge clk_i) sleep_req_i <= 1;
    #1 chk("cancelled", 7'h00, {6'h0, asleep_o});
    chk("frozen", 7'h7F, en);
    @(posedge clk_i) ce_i <= 1;
    @(posedge clk_i) sleep_req_i <= 0;
    @(posedge clk_i) rstn_i <= 0;
    #1 chk("held", 7'h01, {6'h0, asleep_o});
    chk("pdown", 7'h00, en);
    @(posedge clk_i) rstn_i <= 1;
    #1 chk("reset en", 7'h7F, en);
    chk("reset mode", 7'h00, {3'h0, mode_o, asleep_o});
    @(posedge clk_i) sleep_en_i <= 0;
    $display("test corner done");
  endtask
  initial
  begin
    void'($urandom(32'h8B49BB88));
    repeat (16) @(posedge clk_i);
    rstn_i <= 1;
    for (int i = 0; i < 16; i++) go(i[2:0], i[3]);
    corner();
    repeat (24) go(3'($urandom), 1'($urandom));
    close_out();
  end
endmodule
bind sleep_ctrl sleep_ctrl_assertions chk_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .mode_we_i(mode_we_i), .sleep_en_i(sleep_en_i),
  .sleep_req_i(sleep_req_i), .ext_irq_i(ext_irq_i), .int_irq_i(int_irq_i),
  .asleep_o(asleep_o), .mode_err_o(mode_err_o), .cpu_clk_en_o(cpu_clk_en_o),
  .io_clk_en_o(io_clk_en_o), .adc_clk_en_o(adc_clk_en_o), .async_clk_en_o(async_clk_en_o),
  .osc_en_o(osc_en_o), .irq_clk_en_o(irq_clk_en_o), .mem_clk_en_o(mem_clk_en_o),
  .mode_i(mode_i), .mode_o(mode_o)
);
